// ---- design/lcu_pkg.sv ----
/*
  Constants for the link control upper-bits register bank: byte offsets,
  field positions and reset values.
  Assumes a 32-bit APB with word-aligned registers; nothing else.
*/
// What this block does
// - Bit 6 is a read-write common reference clock flag, zero after reset, driven out to the link logic.
// - Bit 7 is a read-write extended sync flag, zero after reset, telling the link logic to send extra ordered sets.
// - Bit 8, clock power management enable, always reads zero and ignores writes.
// - Bit 9, autonomous width disable, is tied to zero.
// - Bit 10 enables an interrupt from the bandwidth-management flag, resets to zero, tied low on upstream or no capability.
// - Bit 11 enables an interrupt from the autonomous-bandwidth flag, resets to zero, tied low likewise.
// - The bandwidth-management flag is set when retraining ends or the PHY changes speed or width, not via link down.
package lcu_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [11:0] LCU_OFS_LINK_CONTROL = 12'h050;
  localparam logic [11:0] LCU_OFS_EVT_STATUS = 12'h054;
  localparam logic [11:0] LCU_OFS_EVT_CLEAR = 12'h058;

  // ----------------------------------------------------------------
  // Field positions in link_control
  // ----------------------------------------------------------------
  localparam int LCU_BIT_COMMON_REFCLK = 6;
  localparam int LCU_BIT_EXTENDED_SYNC = 7;
  localparam int LCU_BIT_CLKPM_ENABLE = 8;
  localparam int LCU_BIT_AUTO_WIDTH_DIS = 9;
  localparam int LCU_BIT_BW_IRQ_EN = 10;
  localparam int LCU_BIT_ABW_IRQ_EN = 11;

  // Event flag positions in the status and clear registers
  localparam int LCU_EVT_BW_MGMT = 0;
  localparam int LCU_EVT_AUTO_BW = 1;
  localparam int LCU_NUM_EVT = 2;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic LCU_RST_CTL_BIT = 1'b0;
  localparam logic [31:0] LCU_RST_RDATA = 32'h0000_0000;
  localparam logic [1:0] LCU_RST_FLAGS = 2'h0;
endpackage

// ---- design/lcu_evt_if.sv ----
/*
  Carrier between the register bank and its event flag unit.
  Assumes both ends run on CLK_SYS.
*/
`timescale 1ns/1ns
interface lcu_evt_if;
  logic [1:0] set;
  logic [1:0] clr;
  logic force_zero;
  logic [1:0] flag;

  modport bank (output set, output clr, output force_zero, input flag);
  modport flags (input set, input clr, input force_zero, output flag);
endinterface

// ---- design/lcu_flags.sv ----
/*
  Sticky event flags with write-one-to-clear; a set beats a clear.
  Assumes set and clear come from logic on CLK_SYS.
*/
`timescale 1ns/1ns
module lcu_flags (
  input wire logic clk,
  input wire logic rst_n,
  lcu_evt_if.flags evt
);
  logic [1:0] flag;
  logic [1:0] next_flag;

  // ----------------------------------------------------------------
  // Flag update, one slice per event
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < lcu_pkg::LCU_NUM_EVT; g++) begin : g_flag
      // Set wins so an event in the clearing cycle is kept
      always_comb begin
        if (evt.force_zero) begin
          next_flag[g] = 1'b0;
        end else if (evt.set[g]) begin
          next_flag[g] = 1'b1;
        end else if (evt.clr[g]) begin
          next_flag[g] = 1'b0;
        end else begin
          next_flag[g] = flag[g];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flag <= lcu_pkg::LCU_RST_FLAGS;
    end else begin
      flag <= next_flag;
    end
  end

  assign evt.flag = flag;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_bw_flag_set: assert property (@(posedge clk) disable iff (!rst_n)
    (evt.set[0] && !evt.force_zero) |=> flag[0])
    else $error("bandwidth flag not set after event");
  a_set_beats_clr: assert property (@(posedge clk) disable iff (!rst_n)
    (evt.set[1] && evt.clr[1] && !evt.force_zero) |=> flag[1])
    else $error("clear beat a simultaneous set");
  a_flag_hold: assert property (@(posedge clk) disable iff (!rst_n)
    (!evt.set[0] && !evt.clr[0] && !evt.force_zero) |=> flag[0] == $past(flag[0]))
    else $error("flag changed with no cause");
  c_flag_cleared: cover property (@(posedge clk) disable iff (!rst_n)
    flag[0] ##1 evt.clr[0] ##1 !flag[0]);
endmodule

// ---- design/lcu_link_control.sv ----
/*
  Upper bits of a switch port's link control register as an APB slave,
  with the bandwidth event flags and their interrupt.
  Assumes the link training machinery drives the event pulses on CLK_SYS;
  the port-role and capability straps come from pins and are synchronised.
*/
// Design decisions made here: the register offsets and register access over APB.
`timescale 1ns/1ns
module lcu_link_control (
  input wire logic CLK_SYS,
  input wire logic RESET_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic UPSTREAM_PORT,
  input wire logic BW_NOTIFICATION_CAPABLE,
  input wire logic RETRAIN_DONE,
  input wire logic AUTONOMOUS_CHANGE,
  input wire logic AUTONOMOUS_BW_EVENT,
  input wire logic LINK_DL_DOWN,
  output logic COMMON_REFCLK_CONFIG,
  output logic EXTENDED_SYNC,
  output logic IRQ
);
  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [11:0] addr, input logic [11:0] ofs);
    hit = (addr == ofs);
  endfunction

  logic setup_phase;
  logic access_phase;
  logic wr_ctl;
  logic wr_clr;
  logic mapped;

  assign setup_phase = PSEL && !PENABLE;
  assign access_phase = PSEL && PENABLE;
  assign wr_ctl = access_phase && PWRITE && hit(PADDR, lcu_pkg::LCU_OFS_LINK_CONTROL);
  assign wr_clr = access_phase && PWRITE && hit(PADDR, lcu_pkg::LCU_OFS_EVT_CLEAR);
  assign mapped = hit(PADDR, lcu_pkg::LCU_OFS_LINK_CONTROL) || hit(PADDR, lcu_pkg::LCU_OFS_EVT_STATUS)
    || hit(PADDR, lcu_pkg::LCU_OFS_EVT_CLEAR);

  // Zero-wait slave keeps the master's timing simple
  assign PREADY = 1'b1;

  // ----------------------------------------------------------------
  // Strap synchronisers
  // ----------------------------------------------------------------
  logic [1:0] strap_meta;
  logic [1:0] strap_sync;
  logic [1:0] next_strap_meta;
  logic [1:0] next_strap_sync;

  // First stage feeds only the second stage
  always_comb begin
    next_strap_meta = {BW_NOTIFICATION_CAPABLE, UPSTREAM_PORT};
    next_strap_sync = strap_meta;
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      strap_meta <= 2'h0;
      strap_sync <= 2'h0;
    end else begin
      strap_meta <= next_strap_meta;
      strap_sync <= next_strap_sync;
    end
  end

  // Enables and flags are only legal on a capable downstream port
  logic notify_allowed;
  assign notify_allowed = !strap_sync[0] && strap_sync[1];

  // ----------------------------------------------------------------
  // Control bits
  // ----------------------------------------------------------------
  logic common_refclk_config;
  logic extended_sync;
  logic bw_mgmt_irq_enable;
  logic autonomous_bw_irq_enable;
  logic next_common_refclk_config;
  logic next_extended_sync;
  logic next_bw_mgmt_irq_enable;
  logic next_autonomous_bw_irq_enable;

  // Byte lanes: bits 6-7 sit in lane 0, bits 10-11 in lane 1
  always_comb begin
    next_common_refclk_config = common_refclk_config;
    next_extended_sync = extended_sync;
    next_bw_mgmt_irq_enable = bw_mgmt_irq_enable;
    next_autonomous_bw_irq_enable = autonomous_bw_irq_enable;
    if (wr_ctl && PSTRB[0]) begin
      next_common_refclk_config = PWDATA[lcu_pkg::LCU_BIT_COMMON_REFCLK];
      next_extended_sync = PWDATA[lcu_pkg::LCU_BIT_EXTENDED_SYNC];
    end
    if (wr_ctl && PSTRB[1]) begin
      next_bw_mgmt_irq_enable = PWDATA[lcu_pkg::LCU_BIT_BW_IRQ_EN];
      next_autonomous_bw_irq_enable = PWDATA[lcu_pkg::LCU_BIT_ABW_IRQ_EN];
    end
    // Hardwired zero, so a strap change also drops a stored enable
    next_bw_mgmt_irq_enable = next_bw_mgmt_irq_enable && notify_allowed;
    next_autonomous_bw_irq_enable = next_autonomous_bw_irq_enable && notify_allowed;
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      common_refclk_config <= lcu_pkg::LCU_RST_CTL_BIT;
      extended_sync <= lcu_pkg::LCU_RST_CTL_BIT;
      bw_mgmt_irq_enable <= lcu_pkg::LCU_RST_CTL_BIT;
      autonomous_bw_irq_enable <= lcu_pkg::LCU_RST_CTL_BIT;
    end else begin
      common_refclk_config <= next_common_refclk_config;
      extended_sync <= next_extended_sync;
      bw_mgmt_irq_enable <= next_bw_mgmt_irq_enable;
      autonomous_bw_irq_enable <= next_autonomous_bw_irq_enable;
    end
  end

  assign COMMON_REFCLK_CONFIG = common_refclk_config;
  assign EXTENDED_SYNC = extended_sync;

  // ----------------------------------------------------------------
  // Event flags
  // ----------------------------------------------------------------
  lcu_evt_if evt ();

  // A change seen through link down is not a bandwidth event
  assign evt.set[lcu_pkg::LCU_EVT_BW_MGMT] = (RETRAIN_DONE || AUTONOMOUS_CHANGE) && !LINK_DL_DOWN;
  assign evt.set[lcu_pkg::LCU_EVT_AUTO_BW] = AUTONOMOUS_BW_EVENT && !LINK_DL_DOWN;
  assign evt.clr = wr_clr && PSTRB[0] ? PWDATA[1:0] : 2'h0;
  assign evt.force_zero = !notify_allowed;

  lcu_flags u_flags (
    .clk(CLK_SYS),
    .rst_n(RESET_N),
    .evt(evt)
  );

  // Level interrupt while an enabled flag stands
  assign IRQ = (evt.flag[lcu_pkg::LCU_EVT_BW_MGMT] && bw_mgmt_irq_enable)
    || (evt.flag[lcu_pkg::LCU_EVT_AUTO_BW] && autonomous_bw_irq_enable);

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  logic [31:0] rdata;
  logic slverr;
  logic [31:0] next_rdata;
  logic next_slverr;

  // Captured in setup so data stand through the access phase
  always_comb begin
    next_rdata = rdata;
    next_slverr = slverr;
    if (setup_phase) begin
      next_rdata = lcu_pkg::LCU_RST_RDATA;
      next_slverr = !mapped;
      if (!PWRITE && hit(PADDR, lcu_pkg::LCU_OFS_LINK_CONTROL)) begin
        next_rdata[lcu_pkg::LCU_BIT_COMMON_REFCLK] = common_refclk_config;
        next_rdata[lcu_pkg::LCU_BIT_EXTENDED_SYNC] = extended_sync;
        next_rdata[lcu_pkg::LCU_BIT_CLKPM_ENABLE] = 1'b0;
        next_rdata[lcu_pkg::LCU_BIT_AUTO_WIDTH_DIS] = 1'b0;
        next_rdata[lcu_pkg::LCU_BIT_BW_IRQ_EN] = bw_mgmt_irq_enable;
        next_rdata[lcu_pkg::LCU_BIT_ABW_IRQ_EN] = autonomous_bw_irq_enable;
        next_rdata[15:12] = 4'h0;
      end else if (!PWRITE && hit(PADDR, lcu_pkg::LCU_OFS_EVT_STATUS)) begin
        next_rdata[1:0] = evt.flag;
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      rdata <= lcu_pkg::LCU_RST_RDATA;
      slverr <= 1'b0;
    end else begin
      rdata <= next_rdata;
      slverr <= next_slverr;
    end
  end

  assign PRDATA = rdata;
  assign PSLVERR = slverr && access_phase;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic rd_ctl_done;
  assign rd_ctl_done = access_phase && !PWRITE && hit(PADDR, lcu_pkg::LCU_OFS_LINK_CONTROL);

  a_refclk_write: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    (wr_ctl && PSTRB[0]) |=> COMMON_REFCLK_CONFIG == $past(PWDATA[lcu_pkg::LCU_BIT_COMMON_REFCLK]))
    else $error("common refclk bit did not take the write");
  a_extended_sync_write: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    (wr_ctl && PSTRB[0]) |=> EXTENDED_SYNC == $past(PWDATA[lcu_pkg::LCU_BIT_EXTENDED_SYNC]))
    else $error("extended sync output did not follow the write");
  a_clkpm_zero: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    rd_ctl_done |-> PRDATA[lcu_pkg::LCU_BIT_CLKPM_ENABLE] == 1'b0)
    else $error("clock power management bit read as one");
  a_width_dis_zero: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    rd_ctl_done |-> PRDATA[lcu_pkg::LCU_BIT_AUTO_WIDTH_DIS] == 1'b0)
    else $error("autonomous width disable read as one");
  a_bw_irq_raise: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    (AUTONOMOUS_CHANGE && !LINK_DL_DOWN && notify_allowed && bw_mgmt_irq_enable && !wr_ctl) |=> IRQ)
    else $error("bandwidth interrupt missing");
  a_abw_irq_raise: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    (evt.flag[1] && autonomous_bw_irq_enable) |-> IRQ)
    else $error("autonomous bandwidth interrupt missing");
  a_enable_tied_low: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    !notify_allowed |=> !bw_mgmt_irq_enable && !autonomous_bw_irq_enable)
    else $error("enable stored on a port that may not notify");
  a_resv_zero: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    rd_ctl_done |-> PRDATA[15:12] == 4'h0 && PRDATA[31:16] == 16'h0000)
    else $error("reserved bits read non-zero");
  a_event_to_irq: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    (RETRAIN_DONE && !LINK_DL_DOWN && notify_allowed && bw_mgmt_irq_enable && !wr_ctl) |=> IRQ)
    else $error("retrain completion raised no interrupt");
  c_irq_seen: cover property (@(posedge CLK_SYS) disable iff (!RESET_N) $rose(IRQ));
  c_ctl_write: cover property (@(posedge CLK_SYS) disable iff (!RESET_N) wr_ctl && PSTRB[1]);
  c_unmapped: cover property (@(posedge CLK_SYS) disable iff (!RESET_N) PSLVERR);
endmodule

// ---- bench/lcu_link_model.sv ----
/*
  Model of the link training machinery beside the register bank.
  Assumes the bench drives req on the rising edge of CLK_SYS.
*/
`timescale 1ns/1ns
module lcu_link_model (
  input wire logic clk,
  input wire logic [3:0] req,
  output logic retrain_done,
  output logic auto_change,
  output logic auto_bw,
  output logic dl_down
);
  // Registered so that every event follows its request bit one cycle later, as a pulse or as a held level
  initial begin
    {dl_down, auto_bw, auto_change, retrain_done} = 4'h0;
  end
  always @(posedge clk) begin
    {dl_down, auto_bw, auto_change, retrain_done} <= req;
  end
endmodule

// ---- bench/tb_top.sv ----
/*
  Self-checking bench for the link control upper bits over APB.
  Assumes zero-wait APB, but waits for PREADY with no local bound; only the watchdog ends a stuck wait.
*/
`timescale 1ns/1ns
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_fail++; \
  $display("wrong value at %0t got %h exp %h", $time, (a), (b)); end end
module tb_top;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  localparam logic [11:0] A_CTL = lcu_pkg::LCU_OFS_LINK_CONTROL;
  localparam logic [11:0] A_STS = lcu_pkg::LCU_OFS_EVT_STATUS;
  localparam logic [11:0] A_CLR = lcu_pkg::LCU_OFS_EVT_CLEAR;
  logic CLK_SYS = 0, RESET_N = 0, PSEL = 0, PENABLE = 0, PWRITE = 0;
  logic [11:0] PADDR = 12'h000;
  logic [31:0] PWDATA = 32'h0000_0000, PRDATA, rd;
  logic [3:0] PSTRB = 4'hF, req = 4'h0;
  logic PREADY, PSLVERR, er, up = 0, cap = 1, rt, ac, ab, dd, crc, es, IRQ;
  int n_fail = 0, total_checks = 0;

  lcu_link_model PRT (.clk(CLK_SYS), .req(req), .retrain_done(rt), .auto_change(ac), .auto_bw(ab), .dl_down(dd));
  lcu_link_control DUT (.CLK_SYS(CLK_SYS), .RESET_N(RESET_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .UPSTREAM_PORT(up), .BW_NOTIFICATION_CAPABLE(cap), .RETRAIN_DONE(rt), .AUTONOMOUS_CHANGE(ac),
    .AUTONOMOUS_BW_EVENT(ab), .LINK_DL_DOWN(dd), .COMMON_REFCLK_CONFIG(crc), .EXTENDED_SYNC(es), .IRQ(IRQ));

  // 25 MHz system clock
  initial forever #20 CLK_SYS = ~CLK_SYS;

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  // Reads in the active region see pre-edge values, so no race with the slave
  // No local limit on the wait: only the watchdog may end a stuck transfer
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge CLK_SYS);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK_SYS);
    PENABLE <= 1'b1;
    do begin
      @(posedge CLK_SYS);
    end while (PREADY !== 1'b1);
    rd = PRDATA;
    er = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  task rchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    `CHK(rd, e)
  endtask

  // Bit 3 of req is the link-down level and survives the pulse
  task pulse(input logic [3:0] k);
    @(posedge CLK_SYS);
    req <= k;
    @(posedge CLK_SYS);
    req <= k & 4'h8;
    repeat (3) @(posedge CLK_SYS);
  endtask

  task stop_test;
    if (n_fail == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Whole run is well under a thousand cycles
  initial begin
    repeat (5000) @(posedge CLK_SYS);
    n_fail++;
    stop_test();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge CLK_SYS);
    RESET_N <= 1'b1;
    repeat (4) @(posedge CLK_SYS);
    rchk(A_CTL, 32'h0000_0000);
    rchk(A_STS, 32'h0000_0000);
    apb(1'b1, A_CTL, 32'hFFFF_FFFF);
    rchk(A_CTL, 32'h0000_0CC0);
    `CHK({crc, es}, 2'b11)
    apb(1'b1, A_CTL, 32'h0000_0440);
    rchk(A_CTL, 32'h0000_0440);
    `CHK({crc, es}, 2'b10)
    // Lane 0 only: bits 6 and 7 follow the data, bit 11 in lane 1 must stay clear
    PSTRB <= 4'h1;
    apb(1'b1, A_CTL, 32'h0000_0C00);
    PSTRB <= 4'hF;
    rchk(A_CTL, 32'h0000_0400);
    `CHK({crc, es}, 2'b00)
    pulse(4'h1);
    rchk(A_STS, 32'h0000_0001);
    `CHK(IRQ, 1'b1)
    apb(1'b1, A_STS, 32'h0000_0000);
    rchk(A_STS, 32'h0000_0001);
    apb(1'b1, A_CLR, 32'h0000_0001);
    rchk(A_STS, 32'h0000_0000);
    `CHK(IRQ, 1'b0)
    pulse(4'h2);
    rchk(A_STS, 32'h0000_0001);
    apb(1'b1, A_CLR, 32'h0000_0001);
    pulse(4'h4);
    rchk(A_STS, 32'h0000_0002);
    `CHK(IRQ, 1'b0)
    apb(1'b1, A_CTL, 32'h0000_0C00);
    // The enable lands at the access edge, so look one edge later
    @(posedge CLK_SYS);
    `CHK(IRQ, 1'b1)
    apb(1'b1, A_CLR, 32'h0000_0002);
    rchk(A_STS, 32'h0000_0000);
    pulse(4'h9);
    rchk(A_STS, 32'h0000_0000);
    req <= 4'h0;
    apb(1'b0, 12'h100, 32'h0000_0000);
    `CHK({er, rd}, {1'b1, 32'h0000_0000})
    up <= 1'b1;
    repeat (4) @(posedge CLK_SYS);
    rchk(A_CTL, 32'h0000_0000);
    pulse(4'h1);
    rchk(A_STS, 32'h0000_0000);
    up <= 1'b0;
    cap <= 1'b0;
    apb(1'b1, A_CTL, 32'h0000_0C00);
    repeat (4) @(posedge CLK_SYS);
    rchk(A_CTL, 32'h0000_0000);
    stop_test();
  end
endmodule
